// [include/console_display_pkg.sv]
// Purpose: Shared constants and types for the console display selector.
// Assumes: Avalon-MM register window of four 32-bit words.
// Notes:   Widths follow the front-panel readouts.
package console_display_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Readout widths
   localparam int DATA_WIDTH = 16;
   localparam int ADDR_WIDTH = 18;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets on the bus
   localparam logic [3:0] CTRL_OFFSET   = 4'h0;
   localparam logic [3:0] DATA_OFFSET   = 4'h4;
   localparam logic [3:0] ADDR_OFFSET   = 4'h8;
   localparam logic [3:0] STATUS_OFFSET = 4'hc;

   // Control and status field positions
   localparam int CTRL_MMU_BIT    = 0;
   localparam int STATUS_VIRT_BIT = 5;
   localparam int STATUS_MSTR_BIT = 6;

   // Reset values
   localparam logic        CTRL_MMU_RESET = 1'b0;
   localparam logic [15:0] DATA_RESET     = 16'h0000;
   localparam logic [17:0] ADDR_RESET     = 18'h00000;

   // Upper three bits of a 16-bit address that select the top page
   localparam logic [2:0] TOP_PAGE_BITS = 3'h7;

   ////////////////////////////////////////////////////////////////////////
   // Readout selection states, one-hot
   typedef enum logic [4:0] {
      ST_RUN  = 5'h01,
      ST_HALT = 5'h02,
      ST_WAIT = 5'h04,
      ST_STEP = 5'h08,
      ST_CONS = 5'h10
   } sel_state_t;

endpackage : console_display_pkg

// [include/addr_form_if.sv]
// Purpose: Carries an address between the selector and the address former.
// Assumes: Purely combinational path.
// Notes:   One modport for each side.
`timescale 1ns/100ps
`default_nettype none
interface addr_form_if;
   logic [17:0] raw;      // Address as held or as keyed in
   logic        mmu;      // Memory management installed
   logic        console;  // Processor not in run: halt, wait, step or console state
   logic [17:0] formed;   // Address to show and drive
   logic        virt;     // Shown value is a virtual address

   modport former (input raw, input mmu, input console,
                   output formed, output virt);
   modport user   (output raw, output mmu, output console,
                   input formed, input virt);
endinterface : addr_form_if
`default_nettype wire

// [design/address_former.sv]
// Purpose: Forms the 18-bit shown address from a raw latch value.
// Assumes: Raw value carries a full 18 bits when memory management is in.
// Notes:   Combinational only.
`timescale 1ns/100ps
`default_nettype none
module address_former
   import console_display_pkg::*;
(
   addr_form_if.former port_f
);

   logic top_page;

   ////////////////////////////////////////////////////////////////////////
   // Top page detect on bits 15..13
   assign top_page = (port_f.raw[15:13] == TOP_PAGE_BITS);

   // Without memory management the top two bits only follow the top page;
   // switch bits 17 and 16 are discarded in that case.
   always_comb
   begin
      if (!port_f.mmu)
      begin
         port_f.formed = {{2{top_page}}, port_f.raw[15:0]};
         port_f.virt   = 1'b0;
      end
      else if (port_f.console)
      begin
         port_f.formed = port_f.raw;  // Full physical address
         port_f.virt   = 1'b0;
      end
      else
      begin
         port_f.formed = {2'b00, port_f.raw[15:0]}; // Virtual while running
         port_f.virt   = 1'b1;
      end
   end

endmodule : address_former
`default_nettype wire

// [design/console_display_select.sv]
// Purpose: Selects what the console data and address readouts show.
// Assumes: Datapath, bus latch and key strobes are synchronous to i_clock.
// Notes:   Key done strobes are one-cycle pulses from the key sequencer.
`timescale 1ns/100ps
`default_nettype none
module console_display_select
   import console_display_pkg::*;
#(
   parameter int DW = DATA_WIDTH,
   parameter int AW = ADDR_WIDTH
)(
   input  wire logic          i_clock,
   input  wire logic          i_reset,
   // Datapath sources
   input  wire logic [DW-1:0] i_dmux_data,
   input  wire logic [DW-1:0] i_general_reg_zero,
   input  wire logic [DW-1:0] i_instruction_register_copy,
   input  wire logic [DW-1:0] i_processor_status_word,
   // Processor state
   input  wire logic          i_prog_halt,
   input  wire logic          i_prog_reset,
   input  wire logic          i_prog_wait,
   input  wire logic          i_single_step,
   input  wire logic          i_console_halt,
   input  wire logic          i_resume,
   // Bus address latch load
   input  wire logic          i_bar_load,
   input  wire logic [AW-1:0] i_bar_value,
   input  wire logic          i_dma_active,
   // Console keys
   input  wire logic          i_load_address_key,
   input  wire logic          i_deposit_key,
   input  wire logic          i_examine_key,
   input  wire logic [AW-1:0] i_switch_value,
   input  wire logic [DW-1:0] i_bus_read_data,
   // Readouts
   output logic      [DW-1:0] o_data_readout,
   output logic      [AW-1:0] o_address_readout,
   output logic      [AW-1:0] o_bus_address,
   output logic               o_virtual_shown,
   output logic               o_console_bus_master,
   // Avalon-MM slave
   input  wire logic [3:0]    i_avs_address,
   input  wire logic          i_avs_read,
   input  wire logic          i_avs_write,
   input  wire logic [31:0]   i_avs_writedata,
   input  wire logic [3:0]    i_avs_byteenable,
   output logic      [31:0]   o_avs_readdata,
   output logic               o_avs_waitrequest
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   sel_state_t    state_q;
   sel_state_t    state_d;
   logic [AW-1:0] bar_q;
   logic [DW-1:0] data_q;
   logic [DW-1:0] data_d;
   logic [AW-1:0] addr_q;
   logic [DW-1:0] key_data_q;
   logic [AW-1:0] key_addr_q;
   logic          key_valid_q;
   logic          mmu_q;
   logic          master_q;
   logic          virt_q;
   logic          ack_q;
   logic [31:0]   rdata_q;
   logic          req;
   logic          key_any;

   addr_form_if form_bus ();

   ////////////////////////////////////////////////////////////////////////
   // Decode helpers

   // True when a byte offset names a mapped register
   function automatic logic is_mapped(input logic [3:0] off);
      is_mapped = (off == CTRL_OFFSET) || (off == DATA_OFFSET) ||
                  (off == ADDR_OFFSET) || (off == STATUS_OFFSET);
   endfunction : is_mapped

   assign key_any = i_load_address_key | i_deposit_key | i_examine_key;

   ////////////////////////////////////////////////////////////////////////
   // Readout selection state

   // Halt and reset outrank wait, wait outranks a console key and a key
   // outranks step; a key enters the console state so its result stays shown.
   always_comb
   begin
      state_d = state_q;
      if (i_prog_halt || i_prog_reset)
         state_d = ST_HALT;
      else if (i_prog_wait)
         state_d = ST_WAIT;
      else if (key_any)
         state_d = ST_CONS;
      else if (i_single_step || i_console_halt)
      begin
         if (state_q != ST_CONS)
            state_d = ST_STEP;
      end
      else if (i_resume)
         state_d = ST_RUN;
   end

   // State register
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
         state_q <= ST_RUN;
      else
         state_q <= state_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Console bus mastership

   // Held from a programmed halt until the processor resumes
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
         master_q <= 1'b0;
      else if (i_prog_halt)
         master_q <= 1'b1;
      else if (i_resume)
         master_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus address latch

   // Only processor cycles and the load-address key load the latch; transfers by another master
   // leave it alone, so the readout may lag the last bus cycle.
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
         bar_q <= ADDR_RESET;
      else if (i_load_address_key)
         bar_q <= i_switch_value;
      else if (i_bar_load && !i_dma_active)
         bar_q <= i_bar_value;
   end

   ////////////////////////////////////////////////////////////////////////
   // Key results

   // The word and address of the last key stay shown until the selection leaves the console state.
   // Examine and deposit take the address just held in the latch.
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         key_data_q  <= DATA_RESET;
         key_addr_q  <= ADDR_RESET;
         key_valid_q <= 1'b0;
      end
      else if (i_load_address_key)
      begin
         key_data_q  <= i_switch_value[DW-1:0];
         key_addr_q  <= i_switch_value;
         key_valid_q <= 1'b1;
      end
      else if (i_deposit_key)
      begin
         key_data_q  <= i_switch_value[DW-1:0];
         key_addr_q  <= bar_q;
         key_valid_q <= 1'b1;
      end
      else if (i_examine_key)
      begin
         key_data_q  <= i_bus_read_data;
         key_addr_q  <= bar_q;
         key_valid_q <= 1'b1;
      end
      else if (state_d != ST_CONS)
         key_valid_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Address forming

   // Console operations use the key address; otherwise the live latch
   assign form_bus.raw     = (state_q == ST_CONS && key_valid_q) ?
                             key_addr_q : bar_q;
   assign form_bus.mmu     = mmu_q;
   assign form_bus.console = (state_q != ST_RUN);

   address_former u_former (
      .port_f (form_bus)
   );

   ////////////////////////////////////////////////////////////////////////
   // Data readout source

   // In run the readout is the datapath multiplexer itself
   always_comb
   begin
      case (state_q)
         ST_RUN:  data_d = i_dmux_data;
         ST_HALT: data_d = i_general_reg_zero;
         ST_WAIT: data_d = i_instruction_register_copy;
         ST_STEP: data_d = i_processor_status_word;
         ST_CONS: data_d = key_valid_q ? key_data_q :
                                         i_processor_status_word;
         default: data_d = i_dmux_data;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Readout registers

   // Readouts follow their sources one clock late, which keeps the
   // panel drivers off combinational paths from the datapath.
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
      begin
         data_q <= DATA_RESET;
         addr_q <= ADDR_RESET;
         virt_q <= 1'b0;
      end
      else
      begin
         data_q <= data_d;
         addr_q <= form_bus.formed;
         virt_q <= form_bus.virt;
      end
   end

   assign o_data_readout       = data_q;
   assign o_address_readout    = addr_q;
   assign o_bus_address        = addr_q;
   assign o_virtual_shown      = virt_q;
   assign o_console_bus_master = master_q;

   ////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave

   // Every access waits exactly one cycle; read data is captured in
   // that first cycle so it stands on the accepting edge.
   assign req               = i_avs_read | i_avs_write;
   assign o_avs_waitrequest = req & ~ack_q;

   // Accept flag
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
         ack_q <= 1'b0;
      else
         ack_q <= req & ~ack_q;
   end

   // Control register, written on the accepting edge
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
         mmu_q <= CTRL_MMU_RESET;
      else if (i_avs_write && ack_q && i_avs_byteenable[0] &&
               i_avs_address == CTRL_OFFSET)
         mmu_q <= i_avs_writedata[CTRL_MMU_BIT];
   end

   // Read data; unmapped offsets read zero
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
         rdata_q <= 32'h00000000;
      else if (i_avs_read && !ack_q)
      begin
         rdata_q <= 32'h00000000;
         if (is_mapped(i_avs_address))
         begin
            case (i_avs_address)
               CTRL_OFFSET:
                  rdata_q[CTRL_MMU_BIT] <= mmu_q;
               DATA_OFFSET:
                  rdata_q[DW-1:0] <= data_q;
               ADDR_OFFSET:
                  rdata_q[AW-1:0] <= addr_q;
               default:
               begin
                  rdata_q[4:0]             <= state_q;
                  rdata_q[STATUS_VIRT_BIT] <= virt_q;
                  rdata_q[STATUS_MSTR_BIT] <= master_q;
               end
            endcase
         end
      end
   end

   assign o_avs_readdata = rdata_q;

endmodule : console_display_select
`default_nettype wire

// [dv/datapath_model.sv]
// Purpose: Stands in for the processor datapath and memory beside the selector.
// Assumes: Memory answers in the same cycle from the shown bus address.
// Notes:   Multiplexer output moves every cycle.
`timescale 1ns/100ps
`default_nettype none
module datapath_model
   import console_display_pkg::*;
(
   input  wire logic                  i_clock,
   input  wire logic                  i_reset,
   input  wire logic [ADDR_WIDTH-1:0] i_bus_address,
   output logic      [DATA_WIDTH-1:0] o_dmux_data,
   output logic      [DATA_WIDTH-1:0] o_bus_read_data
);
   // Multiplexer keeps changing so a stale readout cannot pass
   always_ff @(posedge i_clock)
   begin
      if (i_reset)
         o_dmux_data <= 16'h0000;
      else
         o_dmux_data <= o_dmux_data + 16'h1357;
   end
   // Memory image; word access, so bit 0 is ignored
   assign o_bus_read_data = {i_bus_address[15:1], 1'b0} ^ 16'ha5c3 ^ {14'h0000, i_bus_address[17:16]};
endmodule : datapath_model
`default_nettype wire

// [dv/console_display_select_chk.sv]
// Purpose: Port-level checks of the console readout selector.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Attached by the bind below the module.
`timescale 1ns/100ps
`default_nettype none
module console_display_select_chk
   import console_display_pkg::*;
#(
   parameter int DW = DATA_WIDTH,
   parameter int AW = ADDR_WIDTH
)(
   input wire logic          i_clock,
   input wire logic          i_reset,
   input wire logic [DW-1:0] i_general_reg_zero,
   input wire logic [DW-1:0] i_instruction_register_copy,
   input wire logic          i_prog_halt,
   input wire logic          i_prog_reset,
   input wire logic          i_prog_wait,
   input wire logic          i_load_address_key,
   input wire logic          i_deposit_key,
   input wire logic          i_examine_key,
   input wire logic [AW-1:0] i_switch_value,
   input wire logic [DW-1:0] i_bus_read_data,
   input wire logic [DW-1:0] o_data_readout,
   input wire logic [AW-1:0] o_address_readout,
   input wire logic          o_console_bus_master,
   input wire logic          i_avs_read,
   input wire logic          i_avs_write,
   input wire logic          o_avs_waitrequest
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////////////////////////////////////
   // Triggers; halt and wait outrank every key, so keys count only without them
   sequence s_halt; i_prog_halt || i_prog_reset; endsequence
   sequence s_wait; i_prog_wait && !i_prog_halt && !i_prog_reset; endsequence
   sequence s_calm; !i_prog_halt && !i_prog_reset && !i_prog_wait; endsequence
   sequence s_load; i_load_address_key ##0 s_calm; endsequence
   sequence s_dep; (i_deposit_key && !i_load_address_key) ##0 s_calm; endsequence
   sequence s_examine_key; (i_examine_key && !i_deposit_key && !i_load_address_key) ##0 s_calm; endsequence
   ////////////////////////////////////////////////////////////////////////
   // Readout selection: state lands on the first edge, readout on the second
   chk_halt_reg_zero: assert property (s_halt |-> ##2 o_data_readout == $past(i_general_reg_zero))
      else $error("halt readout is not register zero");
   chk_wait_instr_reg: assert property (s_wait |-> ##2 o_data_readout == $past(i_instruction_register_copy))
      else $error("wait readout is not the instruction register");
   chk_halt_master: assert property (i_prog_halt |=> o_console_bus_master [*2])
      else $error("programmed halt did not give the bus to the console");
   chk_load_both: assert property (s_load |-> ##2 o_data_readout == $past(i_switch_value[15:0], 2)
      && o_address_readout[15:0] == $past(i_switch_value[15:0], 2))
      else $error("load-address readouts disagree with the switches");
   chk_dep_data: assert property (s_dep |-> ##2 o_data_readout == $past(i_switch_value[15:0], 2))
      else $error("deposit readout is not the written word");
   chk_examine_key_data: assert property (s_examine_key |-> ##2 o_data_readout == $past(i_bus_read_data, 2))
      else $error("examine readout is not the word read");
   ////////////////////////////////////////////////////////////////////////
   // Register bus: exactly one wait cycle, none while idle
   chk_req_waits: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
      else $error("new bus request answered without a wait");
   chk_wait_bounded: assert property ((i_avs_read || i_avs_write) |-> ##[0:1] !o_avs_waitrequest)
      else $error("bus wait lasted too long");
   chk_idle_ready: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
      else $error("wait raised with no request");
endmodule : console_display_select_chk

bind console_display_select console_display_select_chk #(.DW(DW), .AW(AW)) u_chk (
   .i_clock(i_clock), .i_reset(i_reset), .i_general_reg_zero(i_general_reg_zero),
   .i_instruction_register_copy(i_instruction_register_copy), .i_prog_halt(i_prog_halt),
   .i_prog_reset(i_prog_reset), .i_prog_wait(i_prog_wait), .i_load_address_key(i_load_address_key),
   .i_deposit_key(i_deposit_key), .i_examine_key(i_examine_key), .i_switch_value(i_switch_value),
   .i_bus_read_data(i_bus_read_data), .o_data_readout(o_data_readout), .o_address_readout(o_address_readout),
   .o_console_bus_master(o_console_bus_master), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_waitrequest(o_avs_waitrequest));
`default_nettype wire

// [dv/console_display_select_tb_top.sv]
// Purpose: Self-checking bench for the console readout selector.
// Assumes: Datapath model supplies the multiplexer and memory data.
// Notes:   Expected readouts come from a small model kept here.
`timescale 1ns/100ps
`default_nettype none
module console_display_select_tb_top
   import console_display_pkg::*;
;
   logic        i_clock = 1'b0;
   logic        i_reset = 1'b1;
   logic [9:0]  ctl = '0;   // Halt,reset,wait,step,chalt,resume,bar,load,dep,examine_key
   logic        dma = 1'b0, rd = 1'b0, wr = 1'b0, virt, mstr, wreq;
   logic [15:0] r0 = '0, ir = '0, psw = '0, dmux, rdat, dmux_prev, o_data;
   logic [17:0] sw = '0, bus_a, o_addr;
   logic [3:0]  aa = '0;
   logic [31:0] wd = '0, rdq, q;
   int          n_fail = 0, comparisons = 0;

   always #5 i_clock = ~i_clock;
   // Multiplexer value one edge back, as RUN shows it
   always @(posedge i_clock) dmux_prev <= dmux;

   console_display_select dut (.i_clock(i_clock), .i_reset(i_reset), .i_dmux_data(dmux),
      .i_general_reg_zero(r0), .i_instruction_register_copy(ir), .i_processor_status_word(psw),
      .i_prog_halt(ctl[0]), .i_prog_reset(ctl[1]), .i_prog_wait(ctl[2]), .i_single_step(ctl[3]),
      .i_console_halt(ctl[4]), .i_resume(ctl[5]), .i_bar_load(ctl[6]), .i_bar_value(sw),
      .i_dma_active(dma), .i_load_address_key(ctl[7]), .i_deposit_key(ctl[8]), .i_examine_key(ctl[9]),
      .i_switch_value(sw), .i_bus_read_data(rdat), .o_data_readout(o_data), .o_address_readout(o_addr),
      .o_bus_address(bus_a), .o_virtual_shown(virt), .o_console_bus_master(mstr), .i_avs_address(aa),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdq), .o_avs_waitrequest(wreq));
   datapath_model u_dp (.i_clock(i_clock), .i_reset(i_reset), .i_bus_address(bus_a),
      .o_dmux_data(dmux), .o_bus_read_data(rdat));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict

   // Strobe one input for a single edge, then stop just after the readout edge
   task automatic pulse(input int k, input logic [17:0] v);
      @(posedge i_clock);
      ctl[k] <= 1'b1;
      sw <= v;
      r0 <= v[15:0];
      ir <= ~v[15:0];
      psw <= v[15:0] ^ 16'h0ff0;
      @(posedge i_clock);
      ctl <= '0;
      @(posedge i_clock);
      #1;
   endtask : pulse

   // Bus cycle: hold until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clock);
      rd <= ~w;
      wr <= w;
      aa <= a;
      wd <= d;
      @(negedge i_clock);
      while (wreq !== 1'b0 && n < 20)
      begin
         n++;
         @(negedge i_clock);
      end
      if (n == 20)
         n_fail++;
      @(posedge i_clock);
      rd <= 1'b0;
      wr <= 1'b0;
      #1;
      q = rdq;
   endtask : bus

   task automatic see(input logic [15:0] d, input logic [17:0] a);
      check(o_data, d);
      check(o_addr, a);
   endtask : see

   // Shown address: top bits filled from the top page unless memory management is in
   function automatic logic [17:0] form(input logic [17:0] v, input logic m, input logic run);
      if (m)
         return run ? {2'b00, v[15:0]} : v;
      return {{2{&v[15:13]}}, v[15:0]};
   endfunction : form

   function automatic logic [15:0] mem(input logic [17:0] a);
      return {a[15:1], 1'b0} ^ 16'ha5c3 ^ {14'h0000, a[17:16]};
   endfunction : mem

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      logic [17:0] v;
      logic [17:0] b;
      void'($urandom(8));
      repeat (4) @(posedge i_clock);
      i_reset <= 1'b0;
      #1;
      see(16'h0000, 18'h00000);
      bus(1'b0, STATUS_OFFSET, 32'h0);
      check(q, 32'h1);
      bus(1'b1, 4'h2, 32'hffffffff);
      bus(1'b0, CTRL_OFFSET, 32'h0);
      check(q, 32'h0);
      for (int i = 0; i < 6; i++)
      begin
         v = (i == 0) ? 18'h0e000 : (i == 1) ? 18'h3dfff : 18'($urandom);
         pulse(6, v);
         see(dmux_prev, form(v, 1'b0, 1'b1));
      end
      b = v;
      @(posedge i_clock);
      dma <= 1'b1;
      pulse(6, ~b);
      see(dmux_prev, form(b, 1'b0, 1'b1));
      @(posedge i_clock);
      dma <= 1'b0;
      bus(1'b0, ADDR_OFFSET, 32'h0);
      check(q[17:0], form(b, 1'b0, 1'b1));
      v = 18'($urandom) & 18'h3fffe;
      pulse(6, v);
      pulse(0, v);
      see(v[15:0], form(v, 1'b0, 1'b0));
      bus(1'b0, STATUS_OFFSET, 32'h0);
      check(q[6:0], 7'h42);
      pulse(2, v);
      see(~v[15:0], form(v, 1'b0, 1'b0));
      for (int k = 3; k < 5; k++)
      begin
         pulse(k, v);
         see(v[15:0] ^ 16'h0ff0, form(v, 1'b0, 1'b0));
      end
      pulse(1, v);
      check(o_data, v[15:0]);
      v = 18'($urandom) | 18'h0e000;
      pulse(7, v);
      see(v[15:0], form(v, 1'b0, 1'b0));
      b = v;
      v = 18'($urandom);
      pulse(8, v);
      see(v[15:0], form(b, 1'b0, 1'b0));
      pulse(9, v);
      see(mem(form(b, 1'b0, 1'b0)), form(b, 1'b0, 1'b0));
      bus(1'b1, CTRL_OFFSET, 32'h1);
      bus(1'b0, CTRL_OFFSET, 32'h0);
      check(q, 32'h1);
      v = 18'($urandom) | 18'h30000;
      pulse(7, v);
      see(v[15:0], v);
      check(virt, 1'b0);
      pulse(5, v);
      see(dmux_prev, form(v, 1'b1, 1'b1));
      check({virt, mstr}, 2'b10);
      pulse(0, v);
      @(posedge i_clock);
      i_reset <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_reset <= 1'b0;
      #1;
      see(16'h0000, 18'h00000);
      check(mstr, 1'b0);
      give_verdict();
   end

   // Watchdog well beyond the hundred or so cycles the tests need
   initial
   begin
      #100000;
      n_fail++;
      give_verdict();
   end
endmodule : console_display_select_tb_top
`default_nettype wire
